// ### core/surb_register_bank.v
// Upper register bank of the synthesizer control map
`timescale 1ns/100ps
`default_nettype none
`include "surb_defines.vh"

// Function
// (RULE_01) Bit 6 picks divided or raw oscillator
// (RULE_02) Bits 5:4 aux power, reset 11
// (RULE_03) Bit 3 turns aux output on
// (RULE_04) ADC enable overrides ADC clock disable
// (RULE_05) Prescale bit divides lock counts by 32
// (RULE_06) Lock state readable at 0x7C bit 0
// (RULE_07) Oscillator counter read at 0x6E/0x6F
// (RULE_08) Doubler filter select bits 7:5, reset 0
// (RULE_09) Doubler bias select bits 1:0, reset 11
// (RULE_10) Aux output register resets to 0x32
// (RULE_11) Reserved and read-only bits ignore writes

module surb_register_bank #(
  parameter LOCK_BASE_LOG2 = 10,
  parameter LOCK_LEN_W = 16
)
(
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // Status from analog core (asynchronous)
  input wire [15:0] osc_counter_value,
  input wire lock_detect,
  input wire adc_enable,
  input wire [1:0] lock_count_select,
  // Aux output controls
  output reg aux_source_select,
  output reg [1:0] aux_power_level,
  output reg aux_output_on,
  // Doubler and misc controls
  output reg [2:0] doubler_filter_select,
  output reg [1:0] doubler_bias_select,
  output reg [1:0] pump_test_select,
  output reg sd_reset,
  output reg adc_clock_off,
  output reg feedback_divider_off,
  output reg lock_count_prescale,
  output wire [LOCK_LEN_W-1:0] lock_count_len
);

  // ****************************************
  // Storage
  // ****************************************
  reg [7:0] r_sd_reset;
  reg [7:0] r_pump_test;
  reg [7:0] r_aux_div_lo;
  reg [7:0] r_buf_div_hi;
  reg [7:0] r_clk2_div_lo;
  reg [7:0] r_osc_mux;
  reg [7:0] r_osc_buf;
  reg [7:0] r_dbl_track;
  reg [7:0] r_quad_track;
  reg [7:0] r_aux_out;
  reg [7:0] r_conv_lock;
  reg [7:0] next_rdata;

  // Two-stage synchronisers. The counter word is only taken once two
  // synchronised samples agree, so a read never shows a half-changed count.
  reg [15:0] cnt_meta;
  reg [15:0] cnt_sync;
  reg [15:0] cnt_prev;
  reg [15:0] cnt_hold;
  reg lock_meta;
  reg lock_sync;
  reg adc_meta;
  reg adc_sync;

  // ****************************************
  // Functions
  // ****************************************
  // Masked write merge used by every writable register
  function [7:0] surb_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      surb_merge = (new_val & mask) | (old_val & ~mask); // RULE_11
    end
  endfunction

  function surb_hit;
    input wr;
    input [6:0] addr;
    input [6:0] ofs;
    begin
      surb_hit = wr && (addr == ofs);
    end
  endfunction

  // ****************************************
  // Write decode
  // ****************************************
  // Writes to read-only or unmapped offsets match no strobe and vanish
  wire wr_sd_reset;
  wire wr_pump_test;
  wire wr_aux_div_lo;
  wire wr_buf_div_hi;
  wire wr_clk2_div_lo;
  wire wr_osc_mux;
  wire wr_osc_buf;
  wire wr_dbl_track;
  wire wr_quad_track;
  wire wr_aux_out;
  wire wr_conv_lock;
  assign wr_sd_reset = surb_hit(reg_wr, reg_addr, `SURB_OFS_SD_RESET);
  assign wr_pump_test = surb_hit(reg_wr, reg_addr, `SURB_OFS_PUMP_TEST);
  assign wr_aux_div_lo = surb_hit(reg_wr, reg_addr, `SURB_OFS_AUX_DIV_LO);
  assign wr_buf_div_hi = surb_hit(reg_wr, reg_addr, `SURB_OFS_BUF_DIV_HI);
  assign wr_clk2_div_lo = surb_hit(reg_wr, reg_addr, `SURB_OFS_CLK2_DIV_LO);
  assign wr_osc_mux = surb_hit(reg_wr, reg_addr, `SURB_OFS_OSC_MUX);
  assign wr_osc_buf = surb_hit(reg_wr, reg_addr, `SURB_OFS_OSC_BUF);
  assign wr_dbl_track = surb_hit(reg_wr, reg_addr, `SURB_OFS_DBL_TRACK);
  assign wr_quad_track = surb_hit(reg_wr, reg_addr, `SURB_OFS_QUAD_TRACK);
  assign wr_aux_out = surb_hit(reg_wr, reg_addr, `SURB_OFS_AUX_OUT);
  assign wr_conv_lock = surb_hit(reg_wr, reg_addr, `SURB_OFS_CONV_LOCK);

  // ****************************************
  // Input synchronisers
  // ****************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_meta <= 16'h0000;
      cnt_sync <= 16'h0000;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      adc_meta <= 1'b0;
      adc_sync <= 1'b0;
    end
    else
    begin
      cnt_meta <= osc_counter_value;
      cnt_sync <= cnt_meta;
      lock_meta <= lock_detect;
      lock_sync <= lock_meta;
      adc_meta <= adc_enable;
      adc_sync <= adc_meta;
    end
  end

  // ****************************************
  // Status capture
  // ****************************************
  // A count that never settles keeps showing its last steady value
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_prev <= 16'h0000;
      cnt_hold <= 16'h0000;
    end
    else
    begin
      cnt_prev <= cnt_sync;
      if (cnt_sync == cnt_prev)
        cnt_hold <= cnt_sync; // RULE_07
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r_sd_reset <= `SURB_RST_SD_RESET;
      r_pump_test <= `SURB_RST_PUMP_TEST;
      r_aux_div_lo <= `SURB_RST_AUX_DIV_LO;
      r_buf_div_hi <= `SURB_RST_BUF_DIV_HI;
      r_clk2_div_lo <= `SURB_RST_CLK2_DIV_LO;
      r_osc_mux <= `SURB_RST_OSC_MUX;
      r_osc_buf <= `SURB_RST_OSC_BUF;
      r_dbl_track <= `SURB_RST_DBL_TRACK; // RULE_08 RULE_09
      r_quad_track <= `SURB_RST_QUAD_TRACK;
      r_aux_out <= `SURB_RST_AUX_OUT; // RULE_10
      r_conv_lock <= `SURB_RST_CONV_LOCK;
    end
    else
    begin
      if (wr_sd_reset)
        r_sd_reset <= surb_merge(r_sd_reset, reg_wdata, `SURB_WM_SD_RESET);
      if (wr_pump_test)
        r_pump_test <= surb_merge(r_pump_test, reg_wdata, `SURB_WM_PUMP_TEST);
      if (wr_aux_div_lo)
        r_aux_div_lo <= surb_merge(r_aux_div_lo, reg_wdata, `SURB_WM_FULL);
      if (wr_buf_div_hi)
        r_buf_div_hi <= surb_merge(r_buf_div_hi, reg_wdata, `SURB_WM_BUF_DIV_HI);
      if (wr_clk2_div_lo)
        r_clk2_div_lo <= surb_merge(r_clk2_div_lo, reg_wdata, `SURB_WM_FULL);
      if (wr_osc_mux)
        r_osc_mux <= surb_merge(r_osc_mux, reg_wdata, `SURB_WM_OSC_MUX);
      if (wr_osc_buf)
        r_osc_buf <= surb_merge(r_osc_buf, reg_wdata, `SURB_WM_OSC_BUF);
      if (wr_dbl_track)
        r_dbl_track <= surb_merge(r_dbl_track, reg_wdata, `SURB_WM_TRACK); // RULE_08 RULE_09
      if (wr_quad_track)
        r_quad_track <= surb_merge(r_quad_track, reg_wdata, `SURB_WM_TRACK);
      if (wr_aux_out)
        r_aux_out <= surb_merge(r_aux_out, reg_wdata, `SURB_WM_AUX_OUT);
      if (wr_conv_lock)
        r_conv_lock <= surb_merge(r_conv_lock, reg_wdata, `SURB_WM_CONV_LOCK);
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @*
  begin
    case (reg_addr)
      `SURB_OFS_SD_RESET: next_rdata = r_sd_reset;
      `SURB_OFS_PUMP_TEST: next_rdata = r_pump_test;
      `SURB_OFS_AUX_DIV_LO: next_rdata = r_aux_div_lo;
      `SURB_OFS_BUF_DIV_HI: next_rdata = r_buf_div_hi;
      `SURB_OFS_CLK2_DIV_LO: next_rdata = r_clk2_div_lo;
      `SURB_OFS_OSC_MUX: next_rdata = r_osc_mux;
      `SURB_OFS_OSC_BUF: next_rdata = r_osc_buf;
      `SURB_OFS_CNT_LO: next_rdata = cnt_hold[7:0]; // RULE_07
      `SURB_OFS_CNT_HI: next_rdata = cnt_hold[15:8]; // RULE_07
      `SURB_OFS_DBL_TRACK: next_rdata = r_dbl_track;
      `SURB_OFS_QUAD_TRACK: next_rdata = r_quad_track;
      `SURB_OFS_AUX_OUT: next_rdata = r_aux_out;
      `SURB_OFS_CONV_LOCK: next_rdata = r_conv_lock;
      `SURB_OFS_LOCK_STATE: next_rdata = {7'h00, lock_sync}; // RULE_06
      // Unmapped offsets read zero so a probe of the map is harmless
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aux_source_select <= 1'b0;
      aux_power_level <= `SURB_RST_AUX_PWR;
      aux_output_on <= 1'b0;
      doubler_filter_select <= 3'h0;
      doubler_bias_select <= `SURB_RST_DBL_BIAS;
      pump_test_select <= `SURB_RST_PUMP;
      sd_reset <= 1'b0;
      adc_clock_off <= 1'b0;
      feedback_divider_off <= 1'b0;
      lock_count_prescale <= 1'b0;
    end
    else
    begin
      aux_source_select <= r_aux_out[`SURB_AUX_SRC_BIT]; // RULE_01
      aux_power_level <= r_aux_out[`SURB_AUX_PWR_HI:`SURB_AUX_PWR_LO]; // RULE_02
      aux_output_on <= r_aux_out[`SURB_AUX_ON_BIT]; // RULE_03
      doubler_filter_select <= r_dbl_track[`SURB_DBL_FILT_HI:`SURB_DBL_FILT_LO]; // RULE_08
      doubler_bias_select <= r_dbl_track[`SURB_DBL_BIAS_HI:`SURB_DBL_BIAS_LO]; // RULE_09
      pump_test_select <= r_pump_test[`SURB_PUMP_HI:`SURB_PUMP_LO];
      sd_reset <= r_sd_reset[`SURB_SD_RESET_BIT];
      // ADC enable wins so calibration is never starved of its clock
      adc_clock_off <= r_conv_lock[`SURB_ADC_CLK_OFF_BIT] & ~adc_sync; // RULE_04
      feedback_divider_off <= r_conv_lock[`SURB_NDIV_OFF_BIT];
      lock_count_prescale <= r_conv_lock[`SURB_LOCK_PRESCALE_BIT]; // RULE_05
    end
  end

  // ****************************************
  // Lock count length
  // ****************************************
  // Registered length is already a flip-flop output
  surb_lock_count #(
    .BASE_LOG2(LOCK_BASE_LOG2),
    .LEN_W(LOCK_LEN_W)
  ) u_lock_count (
    .clk(clk),
    .sys_rst(sys_rst),
    .lock_count_select(lock_count_select),
    .lock_count_prescale(r_conv_lock[`SURB_LOCK_PRESCALE_BIT]),
    .lock_count_len(lock_count_len)
  );

endmodule // surb_register_bank

`default_nettype wire

// ### core/surb_defines.vh
// Register map constants for the synthesizer upper register bank
`ifndef SURB_DEFINES_VH
`define SURB_DEFINES_VH

// Offsets
`define SURB_OFS_SD_RESET 7'h3D
`define SURB_OFS_PUMP_TEST 7'h3E
`define SURB_OFS_AUX_DIV_LO 7'h3F
`define SURB_OFS_BUF_DIV_HI 7'h40
`define SURB_OFS_CLK2_DIV_LO 7'h41
`define SURB_OFS_OSC_MUX 7'h47
`define SURB_OFS_OSC_BUF 7'h52
`define SURB_OFS_CNT_LO 7'h6E
`define SURB_OFS_CNT_HI 7'h6F
`define SURB_OFS_DBL_TRACK 7'h70
`define SURB_OFS_QUAD_TRACK 7'h71
`define SURB_OFS_AUX_OUT 7'h72
`define SURB_OFS_CONV_LOCK 7'h73
`define SURB_OFS_LOCK_STATE 7'h7C

// Reset values
`define SURB_RST_SD_RESET 8'h00
`define SURB_RST_PUMP_TEST 8'h0C
`define SURB_RST_AUX_DIV_LO 8'h80
`define SURB_RST_BUF_DIV_HI 8'h50
`define SURB_RST_CLK2_DIV_LO 8'h28
`define SURB_RST_OSC_MUX 8'hC0
`define SURB_RST_OSC_BUF 8'hF4
`define SURB_RST_DBL_TRACK 8'h03
`define SURB_RST_QUAD_TRACK 8'h60
`define SURB_RST_AUX_OUT 8'h32
`define SURB_RST_CONV_LOCK 8'h00

// Reset values of the decoded control outputs
`define SURB_RST_AUX_PWR 2'h3
`define SURB_RST_DBL_BIAS 2'h3
`define SURB_RST_PUMP 2'h3

// Writable-bit masks; all other bits are fixed zero
`define SURB_WM_SD_RESET 8'h40
`define SURB_WM_PUMP_TEST 8'h0C
`define SURB_WM_FULL 8'hFF
`define SURB_WM_BUF_DIV_HI 8'h7F
`define SURB_WM_OSC_MUX 8'hE0
`define SURB_WM_OSC_BUF 8'hFC
`define SURB_WM_TRACK 8'hE3
`define SURB_WM_AUX_OUT 8'h7A
`define SURB_WM_CONV_LOCK 8'h07

// Field positions
`define SURB_AUX_SRC_BIT 6
`define SURB_AUX_PWR_HI 5
`define SURB_AUX_PWR_LO 4
`define SURB_AUX_ON_BIT 3
`define SURB_ADC_CLK_OFF_BIT 2
`define SURB_NDIV_OFF_BIT 1
`define SURB_LOCK_PRESCALE_BIT 0
`define SURB_DBL_FILT_HI 7
`define SURB_DBL_FILT_LO 5
`define SURB_DBL_BIAS_HI 1
`define SURB_DBL_BIAS_LO 0
`define SURB_PUMP_HI 3
`define SURB_PUMP_LO 2
`define SURB_SD_RESET_BIT 6

// Lock count prescale
`define SURB_LOCK_DIV_LOG2 5

`endif

// ### core/surb_lock_count.v
// Lock detect count length selector with optional divide by 32
`timescale 1ns/100ps
`default_nettype none
`include "surb_defines.vh"

module surb_lock_count #(
  parameter BASE_LOG2 = 10,
  parameter LEN_W = 16
)
(
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire [1:0] lock_count_select,
  input wire lock_count_prescale,
  // Result
  output reg [LEN_W-1:0] lock_count_len
);

  reg [LEN_W-1:0] next_len;

  // Prescaled counts land on 32, 64, 128, 256
  always @*
  begin
    if (lock_count_prescale)
      next_len = {{(LEN_W-1){1'b0}}, 1'b1} << (`SURB_LOCK_DIV_LOG2 + lock_count_select); // RULE_05
    else
      next_len = {{(LEN_W-1){1'b0}}, 1'b1} << (BASE_LOG2 + lock_count_select);
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      lock_count_len <= {LEN_W{1'b0}};
    else
      lock_count_len <= next_len;
  end

endmodule // surb_lock_count

`default_nettype wire

// ### testbench/surb_register_bank_properties.sv
// Checker for the synthesizer upper register bank
`timescale 1ns/100ps
`default_nettype none
module surb_register_bank_properties #(parameter LOCK_LEN_W = 16)
(
  // Clock, reset and register port
  input wire logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  // Status and controls
  input wire logic adc_enable, aux_source_select, aux_output_on, adc_clock_off,
  input wire logic lock_count_prescale,
  input wire logic [1:0] lock_count_select, aux_power_level, doubler_bias_select,
  input wire logic [2:0] doubler_filter_select,
  input wire logic [LOCK_LEN_W-1:0] lock_count_len
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without request");
  AST_AUX_WRITE: assert property (reg_wr && reg_addr == 7'h72 |-> ##2
    {aux_source_select, aux_power_level, aux_output_on} == $past(reg_wdata[6:3], 2))
    else $error("aux controls do not follow write");
  AST_DBL_WRITE: assert property (reg_wr && reg_addr == 7'h70 |-> ##2
    {doubler_filter_select, doubler_bias_select} == {$past(reg_wdata[7:5], 2), $past(reg_wdata[1:0], 2)})
    else $error("doubler controls do not follow write");
  AST_ADC_OVERRIDE: assert property (adc_enable [*4] |=> !adc_clock_off)
    else $error("adc clock off while adc enabled");
  // Length is checked one cycle back so either flop stage timing passes
  AST_PRESCALE: assert property ((lock_count_prescale && $stable(lock_count_select)) [*4]
    |-> $past(lock_count_len) == (16'h0020 << lock_count_select))
    else $error("prescaled lock length wrong");
  AST_LOCK_RSVD: assert property (reg_rd && reg_addr == 7'h7C |=> reg_rdata[7:1] == 7'h00)
    else $error("lock state upper bits not zero");
  AST_RESET_VAL: assert property ($fell(sys_rst) |-> aux_power_level == 2'h3 &&
    !aux_output_on && !aux_source_select && doubler_bias_select == 2'h3 && doubler_filter_select == 3'h0)
    else $error("control outputs not at reset values");
endmodule // surb_register_bank_properties
`default_nettype wire

// ### testbench/surb_host.sv
// Host model driving the register strobe port
`timescale 1ns/100ps
`default_nettype none
module surb_host
(
  // Clock and answer
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Requests
  output logic reg_wr, reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Idle address, and after a write the data too, are inverted so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule // surb_host
`default_nettype wire

// ### testbench/test_synth_upper_register_bank.sv
// Self-checking bench for the synthesizer upper register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check(16'(g), 16'(e))
module test_synth_upper_register_bank;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] osc_counter_value = 16'h0000;
  logic lock_detect = 1'b0;
  logic adc_enable = 1'b0;
  logic [1:0] lock_count_select = 2'h0;
  wire reg_wr, reg_rd, reg_rvalid, aux_source_select, aux_output_on, sd_reset;
  wire adc_clock_off, feedback_divider_off, lock_count_prescale;
  wire [6:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata;
  wire [1:0] aux_power_level, doubler_bias_select, pump_test_select;
  wire [2:0] doubler_filter_select;
  wire [15:0] lock_count_len;
  logic [6:0] ofs [0:10] = '{7'h3D, 7'h3E, 7'h3F, 7'h40, 7'h41, 7'h47, 7'h52, 7'h70, 7'h71,
    7'h72, 7'h73};
  logic [7:0] rst [0:10] = '{8'h00, 8'h0C, 8'h80, 8'h50, 8'h28, 8'hC0, 8'hF4, 8'h03, 8'h60,
    8'h32, 8'h00};
  logic [7:0] msk [0:10] = '{8'h40, 8'h0C, 8'hFF, 8'h7F, 8'hFF, 8'hE0, 8'hFC, 8'hE3, 8'hE3,
    8'h7A, 8'h07};
  logic [7:0] d;
  int failures = 0;
  int compares = 0;
  surb_register_bank dut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .osc_counter_value, .lock_detect, .adc_enable, .lock_count_select,
    .aux_source_select, .aux_power_level, .aux_output_on, .doubler_filter_select,
    .doubler_bias_select, .pump_test_select, .sd_reset, .adc_clock_off, .feedback_divider_off,
    .lock_count_prescale, .lock_count_len);
  surb_host host (.clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  always #2.5 clk = ~clk;
  task check(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task summarize;
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      host.rd(ofs[i], d);
      `CHK(d, rst[i]);
      host.wr(ofs[i], 8'hFF);
      host.rd(ofs[i], d);
      `CHK(d, msk[i]);
      host.wr(ofs[i], 8'h00);
      host.rd(ofs[i], d);
      `CHK(d, 8'h00);
    end
    // Read-only and unmapped places must ignore writes
    host.wr(7'h6E, 8'hFF);
    host.wr(7'h7C, 8'hFF);
    host.wr(7'h50, 8'hFF);
    host.rd(7'h6E, d);
    `CHK(d, 8'h00);
    host.rd(7'h7C, d);
    `CHK(d, 8'h00);
    host.rd(7'h50, d);
    `CHK(d, 8'h00);
    osc_counter_value = 16'hA55A;
    lock_detect = 1'b1;
    settle();
    host.rd(7'h6E, d);
    `CHK(d, 8'h5A);
    host.rd(7'h6F, d);
    `CHK(d, 8'hA5);
    host.rd(7'h7C, d);
    `CHK(d, 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      host.wr(7'h72, 8'(i << 3));
      settle();
      `CHK({aux_source_select, aux_power_level, aux_output_on}, i);
    end
    host.wr(7'h70, 8'hA2);
    settle();
    `CHK({doubler_filter_select, doubler_bias_select}, 5'h16);
    host.wr(7'h73, 8'h07);
    for (int s = 0; s < 4; s++)
    begin
      lock_count_select = 2'(s);
      settle();
      `CHK(lock_count_len, 16'h0020 << s);
    end
    `CHK({adc_clock_off, feedback_divider_off, lock_count_prescale}, 3'h7);
    adc_enable = 1'b1;
    settle();
    `CHK(adc_clock_off, 1'b0);
    host.wr(7'h73, 8'h00);
    settle();
    `CHK(lock_count_len, 16'h2000);
    host.wr(7'h3D, 8'h40);
    host.wr(7'h3E, 8'h0C);
    settle();
    `CHK({sd_reset, pump_test_select}, 3'h7);
    sys_rst = 1'b1;
    settle();
    sys_rst = 1'b0;
    host.rd(7'h72, d);
    `CHK(d, 8'h32);
    summarize();
  end
  initial
  begin
    #50000;
    failures++;
    summarize();
  end
endmodule // test_synth_upper_register_bank
bind surb_register_bank surb_register_bank_properties #(.LOCK_LEN_W(LOCK_LEN_W)) props (.clk,
  .sys_rst, .reg_wr, .reg_rd, .reg_rvalid, .reg_addr, .reg_wdata, .reg_rdata, .adc_enable,
  .aux_source_select, .aux_output_on, .adc_clock_off, .lock_count_prescale, .lock_count_select,
  .aux_power_level, .doubler_bias_select, .doubler_filter_select, .lock_count_len);
`default_nettype wire
